/* File: common/t2u_params.svh */
// constants for the second-timer and uart clock control block
// assumes inclusion by bare name from the design modules and the bench
`ifndef T2U_PARAMS_SVH
`define T2U_PARAMS_SVH
// register indices; byte address is four times the index
`define T2U_IDX_SERBUF 10'h099
`define T2U_IDX_RELOAD 10'h09A
`define T2U_IDX_SLVADR 10'h0A9
`define T2U_IDX_SLVMSK 10'h0B9
`define T2U_IDX_TCTL 10'h0C8
`define T2U_IDX_STAT 10'h0D0
`define T2U_IDX_MASK 10'h0D1
`define T2U_IDX_MISC 10'h0D2
`define T2U_IDX_RCAP 10'h0D3
`define T2U_IDX_COUNT 10'h0D4
`define T2U_IDX_BITOP 10'h0D5
// control register bit positions
`define T2U_B_OVF 7
`define T2U_B_EXT 6
`define T2U_B_RXSEL 5
`define T2U_B_TXSEL 4
`define T2U_B_EXEN 3
`define T2U_B_RUN 2
`define T2U_B_CT 1
`define T2U_B_CPRL 0
// own misc control bit positions
`define T2U_M_IE 0
`define T2U_M_BRR 1
`define T2U_M_RBCK 2
`define T2U_M_TBCK 3
`define T2U_M_SRC 4
// bit-operation fields
`define T2U_BO_VAL 3
// interrupt status bit positions
`define T2U_S_OVF 0
`define T2U_S_EXT 1
`define T2U_S_BRG 2
// reset values and responses
`define T2U_RST8 8'h00
`define T2U_RST16 16'h0000
`define T2U_RST3 3'h0
`define T2U_RST5 5'h00
`define T2U_RESP_OK 2'h0
`define T2U_RESP_ERR 2'h2
// timing
`define T2U_CLK_MHZ 50
`define T2U_TMR_DIV 12
`define T2U_BRG_DIV 16
`define T2U_TOP16 16'hFFFF
`define T2U_TOP8 8'hFF
`endif

/* File: common/t2u_pkg.sv */
// types shared by the second-timer control design
// assumes t2u_params.svh on the include path
package t2u_pkg;
  // control register field view
  typedef struct packed {
    logic ovf;
    logic ext;
    logic rxsel;
    logic txsel;
    logic exen;
    logic run;
    logic ct;
    logic cprl;
  } t2u_tctl_s;
  // uart mode encoding as delivered by the serial port
  typedef enum logic [1:0] {UM_SHIFT, UM_8BIT, UM_9FIX, UM_9VAR} t2u_umode_e;
  // read channel state
  typedef enum logic {RD_IDLE, RD_RESP} t2u_rd_e;
endpackage

/* File: common/t2u_tmr_if.sv */
// carrier between the control top and the timer datapath
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface t2u_tmr_if;
  logic run;
  logic cnt_ext;
  logic cap_mode;
  logic ext_en;
  logic baud_mode;
  logic t2_fall;
  logic t2ex_fall;
  logic [15:0] rcap;
  logic ovf;
  logic ext_evt;
  logic cap_evt;
  logic [15:0] cap_val;
  logic [15:0] count;
  modport ctrl(output run, cnt_ext, cap_mode, ext_en, baud_mode, t2_fall, t2ex_fall, rcap,
               input ovf, ext_evt, cap_evt, cap_val, count);
  modport tmr(input run, cnt_ext, cap_mode, ext_en, baud_mode, t2_fall, t2ex_fall, rcap,
              output ovf, ext_evt, cap_evt, cap_val, count);
endinterface

/* File: core/t2u_timer.sv */
// 16-bit second timer: counting, overflow reload and capture
// assumes synchronised, edge-detected pin pulses from the top
`timescale 1ns/1ps
`include "t2u_params.svh"
module t2u_timer #(
  parameter int DIV = `T2U_TMR_DIV
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // synchronised reset
  t2u_tmr_if.tmr tif // control and events
);
  logic [7:0] div_q;
  logic tick;
  logic [15:0] cnt_q;
  logic ovf_q, ext_q, cap_q;
  logic [15:0] capv_q;
  logic ext_hit;

  // prescaler gives a one-cycle enable for internal timing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= `T2U_RST8;
    end else if (div_q == 8'(DIV - 1)) begin
      div_q <= `T2U_RST8;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // counter input: pin edges in counter mode, prescaler otherwise
  assign tick = tif.run && (tif.cnt_ext ? tif.t2_fall : (div_q == 8'(DIV - 1)));
  assign ext_hit = tif.ext_en && tif.t2ex_fall;

  // count; overflow reloads unless in plain capture mode, which wraps
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= `T2U_RST16;
    end else if (tick && cnt_q == `T2U_TOP16) begin
      cnt_q <= (tif.cap_mode && !tif.baud_mode) ? `T2U_RST16 : tif.rcap;
    end else if (ext_hit && !tif.cap_mode && !tif.baud_mode) begin
      cnt_q <= tif.rcap;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // event pulses; capture only outside baud mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovf_q <= 1'b0;
      ext_q <= 1'b0;
      cap_q <= 1'b0;
      capv_q <= `T2U_RST16;
    end else begin
      ovf_q <= tick && cnt_q == `T2U_TOP16;
      ext_q <= ext_hit;
      cap_q <= ext_hit && tif.cap_mode && !tif.baud_mode;
      if (ext_hit && tif.cap_mode && !tif.baud_mode) begin
        capv_q <= cnt_q;
      end
    end
  end

  assign tif.ovf = ovf_q;
  assign tif.ext_evt = ext_q;
  assign tif.cap_evt = cap_q;
  assign tif.cap_val = capv_q;
  assign tif.count = cnt_q;

  // a trigger reload is not counting, so it may still move a stopped timer
  chk_stop_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!tif.run && !ext_hit) |=> $stable(cnt_q)) else $error("timer moved while stopped");
endmodule

/* File: core/t2u_top.sv */
// second-timer control, uart clock routing and uart address registers
// Functional notes
// - overflow flag bit 7 sets on timer overflow only when both clock selects clear
// - hardware never clears the overflow flag; software writes it to zero
// - external flag bit 6 with timer interrupt enabled requests the timer interrupt
// - bit 5 set routes timer overflows to receive clock in modes 1 and 3 while misc bit 2 is clear
// - control register resets to zero and every bit is singly writable
// - serial buffer has no reset value
// - eight-bit baud reload register at index 9A, reset zero
// - eight-bit slave address mask register at index B9, reset zero
// - eight-bit slave address register at index A9, reset zero
// - internal baud generator clocks serial modes 1, 3 and optionally mode 0
// assumes an AXI4-Lite master on SYS_CLK_IN and timer 1 overflow pulses on the same clock
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "t2u_params.svh"
module t2u_top #(
  parameter int BRG_DIV = `T2U_BRG_DIV
) (
  input wire logic SYS_CLK_IN, // 50 MHz clock
  input wire logic RST_N_IN, // async reset, low
  input wire logic [11:0] S_AXI_AWADDR_IN, // write address
  input wire logic S_AXI_AWVALID_IN, // write address valid
  output logic S_AXI_AWREADY_OUT, // write address ready
  input wire logic [31:0] S_AXI_WDATA_IN, // write data
  input wire logic [3:0] S_AXI_WSTRB_IN, // byte strobes
  input wire logic S_AXI_WVALID_IN, // write data valid
  output logic S_AXI_WREADY_OUT, // write data ready
  output logic [1:0] S_AXI_BRESP_OUT, // write response
  output logic S_AXI_BVALID_OUT, // write response valid
  input wire logic S_AXI_BREADY_IN, // write response ready
  input wire logic [11:0] S_AXI_ARADDR_IN, // read address
  input wire logic S_AXI_ARVALID_IN, // read address valid
  output logic S_AXI_ARREADY_OUT, // read address ready
  output logic [31:0] S_AXI_RDATA_OUT, // read data
  output logic [1:0] S_AXI_RRESP_OUT, // read response
  output logic S_AXI_RVALID_OUT, // read data valid
  input wire logic S_AXI_RREADY_IN, // read data ready
  input wire logic T2_PIN_IN, // timer count pin, async
  input wire logic T2EX_PIN_IN, // timer trigger pin, async
  input wire logic T1_OVF_IN, // timer 1 overflow pulse
  input wire logic [1:0] UART_MODE_IN, // serial mode from uart
  output logic RX_CLK_OUT, // receive clock pulse
  output logic TX_CLK_OUT, // transmit clock pulse
  output logic T2_IRQ_OUT, // timer interrupt request
  output logic IRQ_OUT // masked status interrupt
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] t2_sync_q, t2ex_sync_q;
  t2u_pkg::t2u_tctl_s tctl_q;
  logic [7:0] serbuf_q, reload_q, slvadr_q, slvmsk_q;
  logic [4:0] misc_q;
  logic [15:0] rcap_q;
  logic [2:0] stat_q, mask_q;
  logic [7:0] brg_q, brg_div_q;
  logic brg_tick;
  logic aw_got_q, w_got_q;
  logic [9:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  t2u_pkg::t2u_rd_e rd_q;
  t2u_tmr_if tif();

  // decode a byte address to a register index; low two bits are ignored
  function automatic logic [9:0] idx_of(input logic [11:0] a);
    idx_of = a[11:2];
  endfunction

  function automatic logic mapped(input logic [9:0] i);
    mapped = (i == `T2U_IDX_SERBUF) || (i == `T2U_IDX_RELOAD) || (i == `T2U_IDX_SLVADR) ||
             (i == `T2U_IDX_SLVMSK) || (i == `T2U_IDX_TCTL) || (i == `T2U_IDX_STAT) ||
             (i == `T2U_IDX_MASK) || (i == `T2U_IDX_MISC) || (i == `T2U_IDX_RCAP) ||
             (i == `T2U_IDX_COUNT) || (i == `T2U_IDX_BITOP);
  endfunction

  // merge a strobed byte into an old byte
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  // reset release through two flops so deassertion is clean
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pin synchronisers; third stage only feeds the edge detector
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      t2_sync_q <= 3'b111;
      t2ex_sync_q <= 3'b111;
    end else begin
      t2_sync_q <= {t2_sync_q[1:0], T2_PIN_IN};
      t2ex_sync_q <= {t2ex_sync_q[1:0], T2EX_PIN_IN};
    end
  end

  // timer connection
  assign tif.run = tctl_q.run;
  assign tif.cnt_ext = tctl_q.ct;
  assign tif.cap_mode = tctl_q.cprl;
  assign tif.ext_en = tctl_q.exen;
  assign tif.baud_mode = tctl_q.rxsel || tctl_q.txsel;
  assign tif.t2_fall = t2_sync_q[2] && !t2_sync_q[1];
  assign tif.t2ex_fall = t2ex_sync_q[2] && !t2ex_sync_q[1];
  assign tif.rcap = rcap_q;

  t2u_timer #(.DIV(`T2U_TMR_DIV)) u_timer (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(rst_n),
    .tif(tif)
  );

  // write channel: address and data taken in either order, one write in flight
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_idx_q <= 10'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= `T2U_RESP_OK;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_got_q <= 1'b1;
        aw_idx_q <= idx_of(S_AXI_AWADDR_IN);
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_IN;
        wstrb_q <= S_AXI_WSTRB_IN;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= mapped(aw_idx_q) ? `T2U_RESP_OK : `T2U_RESP_ERR;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end
  assign wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID_OUT;

  // ready flags held as flops; dropped once the item is in hand
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_got_q && !(S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) &&
                           !S_AXI_BVALID_OUT;
      S_AXI_WREADY_OUT <= !w_got_q && !(S_AXI_WVALID_IN && S_AXI_WREADY_OUT) &&
                          !S_AXI_BVALID_OUT;
    end
  end

  // plain registers: reload, slave address and mask bytes, misc control and interrupt mask
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= `T2U_RST8;
      slvadr_q <= `T2U_RST8;
      slvmsk_q <= `T2U_RST8;
      misc_q <= `T2U_RST5;
      mask_q <= `T2U_RST3;
    end else if (wr_fire) begin
      if (aw_idx_q == `T2U_IDX_RELOAD) begin
        reload_q <= merge8(reload_q, wdata_q[7:0], wstrb_q[0]);
      end
      if (aw_idx_q == `T2U_IDX_SLVADR) begin
        slvadr_q <= merge8(slvadr_q, wdata_q[7:0], wstrb_q[0]);
      end
      if (aw_idx_q == `T2U_IDX_SLVMSK) begin
        slvmsk_q <= merge8(slvmsk_q, wdata_q[7:0], wstrb_q[0]);
      end
      if (aw_idx_q == `T2U_IDX_MISC && wstrb_q[0]) misc_q <= wdata_q[4:0];
      if (aw_idx_q == `T2U_IDX_MASK && wstrb_q[0]) mask_q <= wdata_q[2:0];
    end
  end

  // serial buffer carries no reset: content is undefined until written
  always_ff @(posedge SYS_CLK_IN) begin
    if (wr_fire && aw_idx_q == `T2U_IDX_SERBUF && wstrb_q[0]) begin
      serbuf_q <= wdata_q[7:0];
    end
  end

  // reload/capture value; a capture in the same cycle wins over software
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rcap_q <= `T2U_RST16;
    end else if (tif.cap_evt) begin
      rcap_q <= tif.cap_val;
    end else if (wr_fire && aw_idx_q == `T2U_IDX_RCAP) begin
      rcap_q <= {merge8(rcap_q[15:8], wdata_q[15:8], wstrb_q[1]),
                 merge8(rcap_q[7:0], wdata_q[7:0], wstrb_q[0])};
    end
  end

  // control register: whole-byte write or single-bit write; hardware sets win
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tctl_q <= `T2U_RST8;
    end else begin
      if (wr_fire && aw_idx_q == `T2U_IDX_TCTL && wstrb_q[0]) begin
        tctl_q <= wdata_q[7:0];
      end else if (wr_fire && aw_idx_q == `T2U_IDX_BITOP && wstrb_q[0]) begin
        tctl_q[wdata_q[2:0]] <= wdata_q[`T2U_BO_VAL];
      end
      if (tif.ovf && !tctl_q.rxsel && !tctl_q.txsel) begin
        tctl_q[`T2U_B_OVF] <= 1'b1;
      end
      if (tif.ext_evt) begin
        tctl_q[`T2U_B_EXT] <= 1'b1;
      end
    end
  end

  // sticky interrupt status, write one to clear, new events win
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= `T2U_RST3;
    end else begin
      stat_q <= (stat_q & ~((wr_fire && aw_idx_q == `T2U_IDX_STAT && wstrb_q[0]) ?
                 wdata_q[2:0] : 3'h0)) |
                {brg_tick, tif.ext_evt, tif.ovf && !tctl_q.rxsel && !tctl_q.txsel};
    end
  end

  // internal baud generator: counts from reload to top on a divided enable
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      brg_div_q <= `T2U_RST8;
      brg_q <= `T2U_RST8;
    end else if (!misc_q[`T2U_M_BRR]) begin
      brg_div_q <= `T2U_RST8;
      brg_q <= reload_q;
    end else begin
      brg_div_q <= (brg_div_q == 8'(BRG_DIV - 1)) ? `T2U_RST8 : brg_div_q + 8'h01;
      if (brg_div_q == 8'(BRG_DIV - 1)) begin
        brg_q <= (brg_q == `T2U_TOP8) ? reload_q : brg_q + 8'h01;
      end
    end
  end
  assign brg_tick = misc_q[`T2U_M_BRR] && brg_div_q == 8'(BRG_DIV - 1) && brg_q == `T2U_TOP8;

  // serial clock routing; mode 0 only sees the generator when asked, mode 2 gets no clock
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RX_CLK_OUT <= 1'b0;
      TX_CLK_OUT <= 1'b0;
    end else begin
      unique case (t2u_pkg::t2u_umode_e'(UART_MODE_IN))
        t2u_pkg::UM_8BIT, t2u_pkg::UM_9VAR: begin
          RX_CLK_OUT <= misc_q[`T2U_M_RBCK] ? brg_tick :
                        tctl_q.rxsel ? tif.ovf : T1_OVF_IN;
          TX_CLK_OUT <= misc_q[`T2U_M_TBCK] ? brg_tick :
                        tctl_q.txsel ? tif.ovf : T1_OVF_IN;
        end
        t2u_pkg::UM_SHIFT: begin
          RX_CLK_OUT <= misc_q[`T2U_M_SRC] && brg_tick;
          TX_CLK_OUT <= misc_q[`T2U_M_SRC] && brg_tick;
        end
        t2u_pkg::UM_9FIX: begin
          RX_CLK_OUT <= 1'b0;
          TX_CLK_OUT <= 1'b0;
        end
      endcase
    end
  end

  // interrupt outputs, registered
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      T2_IRQ_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      T2_IRQ_OUT <= misc_q[`T2U_M_IE] && (tctl_q.ext || tctl_q.ovf);
      IRQ_OUT <= |(stat_q & mask_q);
    end
  end

  // read channel: one read in flight, data valid one cycle after address
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= t2u_pkg::RD_IDLE;
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h00000000;
      S_AXI_RRESP_OUT <= `T2U_RESP_OK;
    end else begin
      unique case (rd_q)
        t2u_pkg::RD_IDLE: begin
          S_AXI_ARREADY_OUT <= !(S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT);
          if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            rd_q <= t2u_pkg::RD_RESP;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RRESP_OUT <= mapped(idx_of(S_AXI_ARADDR_IN)) ? `T2U_RESP_OK : `T2U_RESP_ERR;
            unique case (idx_of(S_AXI_ARADDR_IN))
              `T2U_IDX_SERBUF: S_AXI_RDATA_OUT <= {24'h000000, serbuf_q};
              `T2U_IDX_RELOAD: S_AXI_RDATA_OUT <= {24'h000000, reload_q};
              `T2U_IDX_SLVADR: S_AXI_RDATA_OUT <= {24'h000000, slvadr_q};
              `T2U_IDX_SLVMSK: S_AXI_RDATA_OUT <= {24'h000000, slvmsk_q};
              `T2U_IDX_TCTL: S_AXI_RDATA_OUT <= {24'h000000, tctl_q};
              `T2U_IDX_STAT: S_AXI_RDATA_OUT <= {29'h00000000, stat_q};
              `T2U_IDX_MASK: S_AXI_RDATA_OUT <= {29'h00000000, mask_q};
              `T2U_IDX_MISC: S_AXI_RDATA_OUT <= {27'h0000000, misc_q};
              `T2U_IDX_RCAP: S_AXI_RDATA_OUT <= {16'h0000, rcap_q};
              `T2U_IDX_COUNT: S_AXI_RDATA_OUT <= {16'h0000, tif.count};
              default: S_AXI_RDATA_OUT <= 32'h00000000;
            endcase
          end
        end
        t2u_pkg::RD_RESP: begin
          S_AXI_ARREADY_OUT <= 1'b0;
          if (S_AXI_RREADY_IN) begin
            rd_q <= t2u_pkg::RD_IDLE;
            S_AXI_RVALID_OUT <= 1'b0;
          end
        end
      endcase
    end
  end

  sequence s_ovf_gated;
    tif.ovf && !tctl_q.rxsel && !tctl_q.txsel;
  endsequence
  sequence s_flag_up;
    tctl_q.ovf;
  endsequence

  chk_ovf_sets_flag: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    s_ovf_gated |=> s_flag_up) else $error("overflow flag not set");
  chk_ovf_baud_quiet: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (!tctl_q.ovf && !wr_fire && (tctl_q.rxsel || tctl_q.txsel)) |=> !tctl_q.ovf)
    else $error("overflow flag set in baud mode");
  chk_flag_no_hw_clr: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (tctl_q.ovf && !wr_fire) |=> tctl_q.ovf) else $error("flag cleared by hardware");
  chk_ext_irq_req: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (tctl_q.ext && misc_q[`T2U_M_IE]) |=> T2_IRQ_OUT) else $error("no timer request");
  chk_rx_route_t2: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (UART_MODE_IN == 2'h1 && tctl_q.rxsel && !misc_q[`T2U_M_RBCK] && tif.ovf) |=> RX_CLK_OUT)
    else $error("receive clock lost timer overflow");
  chk_tx_route_t1: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (UART_MODE_IN == 2'h3 && !tctl_q.txsel && !misc_q[`T2U_M_TBCK]) |=>
    (TX_CLK_OUT == $past(T1_OVF_IN))) else $error("transmit clock not timer 1");
  chk_bitop_write: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (wr_fire && aw_idx_q == `T2U_IDX_BITOP && wstrb_q[0] && wdata_q[2:0] == 3'(`T2U_B_RUN))
    |=> (tctl_q.run == $past(wdata_q[`T2U_BO_VAL]))) else $error("bit write failed");
  chk_reload_write: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (wr_fire && aw_idx_q == `T2U_IDX_RELOAD && wstrb_q[0]) |=>
    (reload_q == $past(wdata_q[7:0]))) else $error("reload register not written");
  chk_slvmsk_hold: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    !(wr_fire && aw_idx_q == `T2U_IDX_SLVMSK) |=> $stable(slvmsk_q))
    else $error("mask register changed");
  chk_slvadr_hold: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    !(wr_fire && aw_idx_q == `T2U_IDX_SLVADR) |=> $stable(slvadr_q))
    else $error("address register changed");
  chk_brg_mode0: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (UART_MODE_IN == 2'h0 && misc_q[`T2U_M_SRC] && brg_tick) |=> (RX_CLK_OUT && TX_CLK_OUT))
    else $error("generator missing in mode 0");
  chk_serbuf_write: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
    (wr_fire && aw_idx_q == `T2U_IDX_SERBUF && wstrb_q[0]) |=>
    (serbuf_q == $past(wdata_q[7:0]))) else $error("serial buffer not written");
endmodule

/* File: sim/tb_t2u_top.sv */
// self-checking bench for the second-timer control top
// assumes the design header on the include path and one 50 MHz clock
`timescale 1ns/1ps
`include "t2u_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_t2u_top;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, t2ex = 1'b1, t1 = 1'b0;
  logic [1:0] um = 2'h1, bresp, rresp;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000, rdata;
  logic awrdy, wrdy, bv, arrdy, rv, rxc, txc, t2i, irq;
  int failures = 0, n_tests = 0, rxn, txn;
  // free-running 50 MHz clock
  always #10 clk = ~clk;
  // short generator divide keeps the baud runs brief
  t2u_top #(.BRG_DIV(1)) dut_u (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(1'b1),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(1'b1), .T2_PIN_IN(1'b1), .T2EX_PIN_IN(t2ex), .T1_OVF_IN(t1),
    .UART_MODE_IN(um), .RX_CLK_OUT(rxc), .TX_CLK_OUT(txc), .T2_IRQ_OUT(t2i), .IRQ_OUT(irq));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ready lines drop once an item is taken, so each valid is released when its ready is seen
  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int k;
    awa <= {i, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    if (k == 40) begin
      failures++;
      wrap_up();
    end
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int k;
    ara <= {i, 2'h0};
    arv <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
      if (rv) break;
    end
    if (k == 40) begin
      failures++;
      wrap_up();
    end
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask
  // counts clock pulses over n cycles, optionally after one timer 1 overflow
  task automatic watch(input int n, input logic p);
    int k;
    rxn = 0;
    txn = 0;
    t1 <= p;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      t1 <= 1'b0;
      rxn += rxc;
      txn += txc;
    end
  endtask
  task automatic t_reset;
    rd(`T2U_IDX_RELOAD, 32'h0);
    rd(`T2U_IDX_SLVADR, 32'h0);
    rd(`T2U_IDX_SLVMSK, 32'h0);
    rd(`T2U_IDX_TCTL, 32'h0);
    rd(10'h000, 32'h0, 2'h2);
  endtask
  task automatic t_regs;
    wr(`T2U_IDX_SERBUF, 32'hA5);
    rd(`T2U_IDX_SERBUF, 32'hA5);
    wr(`T2U_IDX_RELOAD, 32'h3C);
    rd(`T2U_IDX_RELOAD, 32'h3C);
    wr(`T2U_IDX_SLVADR, 32'h5A);
    rd(`T2U_IDX_SLVADR, 32'h5A);
    wr(`T2U_IDX_SLVMSK, 32'hC3);
    rd(`T2U_IDX_SLVMSK, 32'hC3);
    wr(`T2U_IDX_BITOP, 32'hC);
    rd(`T2U_IDX_TCTL, 32'h10);
    wr(`T2U_IDX_BITOP, 32'h4);
    rd(`T2U_IDX_TCTL, 32'h0);
    // single-bit set and clear of the run bit; too short for any overflow
    wr(`T2U_IDX_BITOP, 32'hA);
    rd(`T2U_IDX_TCTL, 32'h04);
    wr(`T2U_IDX_BITOP, 32'h2);
    rd(`T2U_IDX_TCTL, 32'h0);
  endtask
  // trigger reload puts the count near the top so overflows come quickly
  task automatic t_timer;
    wr(`T2U_IDX_RCAP, 32'hFFF0);
    wr(`T2U_IDX_TCTL, 32'h08);
    t2ex <= 1'b0;
    repeat (4) @(posedge clk);
    t2ex <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`T2U_IDX_TCTL, 32'h48);
    rd(`T2U_IDX_COUNT, 32'hFFF0);
    wr(`T2U_IDX_MISC, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(t2i, 1'b1)
    wr(`T2U_IDX_TCTL, 32'h0C);
    watch(230, 1'b0);
    rd(`T2U_IDX_TCTL, 32'h8C);
    `CHK(rxn, 0)
    watch(200, 1'b0);
    rd(`T2U_IDX_TCTL, 32'h8C);
    wr(`T2U_IDX_TCTL, 32'h00);
    rd(`T2U_IDX_TCTL, 32'h00);
  endtask
  task automatic t_route;
    wr(`T2U_IDX_TCTL, 32'h34);
    watch(250, 1'b0);
    `CHK(rxn > 0, 1'b1)
    `CHK(txn, rxn)
    rd(`T2U_IDX_TCTL, 32'h34);
    wr(`T2U_IDX_TCTL, 32'h00);
    watch(5, 1'b1);
    `CHK(rxn, 1)
    `CHK(txn, 1)
    um <= 2'h2;
    watch(5, 1'b1);
    `CHK(rxn, 0)
    um <= 2'h3;
    watch(5, 1'b1);
    `CHK(rxn, 1)
    um <= 2'h1;
  endtask
  // generator ticks also feed the sticky status and the masked interrupt
  task automatic t_brg;
    wr(`T2U_IDX_RELOAD, 32'hFC);
    wr(`T2U_IDX_MASK, 32'h4);
    wr(`T2U_IDX_MISC, 32'h0F);
    watch(40, 1'b0);
    `CHK(rxn > 0, 1'b1)
    `CHK(txn, rxn)
    `CHK(irq, 1'b1)
    um <= 2'h0;
    watch(40, 1'b0);
    `CHK(rxn, 0)
    wr(`T2U_IDX_MISC, 32'h1F);
    watch(40, 1'b0);
    `CHK(rxn > 0, 1'b1)
    wr(`T2U_IDX_MISC, 32'h0);
    wr(`T2U_IDX_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(`T2U_IDX_MASK, 32'h4);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(`T2U_IDX_STAT, 32'h7);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`T2U_IDX_STAT, 32'h0);
  endtask
  // reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_timer();
    t_route();
    t_brg();
    wrap_up();
  end
endmodule
